// *** keyboard_host_port_pkg.sv ***
// constants and carriers for the keyboard host port
package keyboard_host_port_pkg;

	// host i/o map
	localparam logic [15:0] DATA_PORT_ADDR = 16'h0060;
	localparam logic [15:0] CTRL_PORT_ADDR = 16'h0064;

	// flag positions in the host flags byte, and the address bit that selects the command flag
	localparam int OUT_FULL_BIT = 0;
	localparam int IN_FULL_BIT  = 1;
	localparam int CMD_BIT      = 3;
	localparam int ADDR_CMD_BIT = 2;

	// values after reset
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] PORT2_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET  = 8'h00;

	// port 2 bit positions
	localparam int KBD_RESET_PORT_BIT = 0;
	localparam int A20_PORT_BIT       = 1;
	localparam int AUX_DAT_PORT_BIT   = 2;
	localparam int AUX_CLK_PORT_BIT   = 3;
	localparam int KBD_IRQ_PORT_BIT   = 4;
	localparam int AUX_IRQ_PORT_BIT   = 5;
	localparam int KBD_CLK_PORT_BIT   = 6;
	localparam int KBD_DAT_PORT_BIT   = 7;

	// synchroniser depth
	localparam int SYNC_STAGES = 2;

	// serial pin order: kbd clk, kbd dat, aux clk, aux dat
	localparam int SER_PINS = 4;

	typedef struct packed {
		logic [3:0] user7to4;
		logic       cmdFlag;
		logic       user2;
		logic       inFullFlag;
		logic       outFullFlag;
	} host_flags_t;

	typedef struct packed {
		logic wrOutByte;
		logic rdInByte;
		logic wrFlags;
		logic wrPort2;
		logic enFlags;
		logic haltInstr;
		logic stopInstr;
	} ctrl_req_t;

	typedef enum logic [1:0] {
		CORE_RUN,
		CORE_HALTED,
		CORE_STOPPED
	} core_state_t;

endpackage

// *** keyboard_host_port.sv ***
// host mailbox, port pin mapping and power-down control
`timescale 1ns/1ps

// Operation
// - 0x60 write is data in, read is data out; 0x64 command in, flags out.
// - data write loads byte, clears command flag, sets input full.
// - command write loads byte, sets command flag, sets input full.
// - with flags enabled, host data read clears output full and kbd irq.
// - controller output write sets output full in flag bit 0.
// - flag bit 3 holds address line 2 captured at each host write.
// - flags enabled: kbd irq follows output full if port bit set, else low.
// - kbd irq output is low after reset.
// - flags not enabled: kbd irq follows its port bit.
// - flags enabled and port bit set: aux irq is inverted input full.
// - flags not enabled: aux irq follows its port bit.
// - a20 port bit routes to its gpio pin under pin config.
// - kbd reset port bit selectable onto gpio pin; may kick watchdog.
// - four serial pins are inverted port bits, read back for sampling.
// - serial pins are open drain, pulling low only.
// - halt stops alu clock until reset or host input write.
// - host write wake vectors to interrupt if enabled, else next instr.
// - reset wake restarts the core at program address zero.
// - stop disables oscillator until reset or host input write.
// - exactly two internal interrupts: input full and timer overflow.
// - flags clear to zero on reset; host read only, controller reads all, writes bits 7:4 and 2 only.
// - controller read of input byte clears input full and its interrupt.
module keyboard_host_port
	import keyboard_host_port_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic [15:0]         isaAddr,
	input  wire logic                isaAen,
	input  wire logic                isaRdN,
	input  wire logic                isaWrN,
	input  wire logic [7:0]          isaDataIn,
	output logic      [7:0]          isaDataOut,
	output logic                     isaDataOe,
	output logic                     kbdIrqOut,
	output logic                     auxIrqOut,
	input  wire ctrl_req_t           ctrlReq,
	input  wire logic [7:0]          ctrlOutByte,
	input  wire logic [7:0]          ctrlFlagsByte,
	input  wire logic [7:0]          ctrlPortByte,
	input  wire logic                ibfIrqEn,
	input  wire logic                timerOverflow,
	output logic      [7:0]          ctrlInByte,
	output host_flags_t              ctrlFlags,
	output logic      [7:0]          ctrlPort,
	output logic                     irqInFull,
	output logic                     irqTimer,
	output logic                     aluClkEn,
	output logic                     oscEn,
	output logic                     wakeVector,
	output logic                     wakeNext,
	output logic                     coreRestart,
	input  wire logic                a20Route,
	input  wire logic                kbdRstRoute,
	input  wire logic                a20UserOut,
	input  wire logic                kbdRstUserOut,
	input  wire logic                wdtKickEn,
	output logic                     gpioA20Pin,
	output logic                     gpioKbdResetPin,
	output logic                     wdtKick,
	input  wire logic [SER_PINS-1:0] serPinIn,
	output logic      [SER_PINS-1:0] serPinOut,
	output logic      [SER_PINS-1:0] serPinOe,
	output logic      [SER_PINS-1:0] serSample
);

	////////////////////////////////////////////////////////////////////////
	// host pin synchronisers

	logic [SYNC_STAGES-1:0] rdNSync_q;
	logic [SYNC_STAGES-1:0] wrNSync_q;
	logic [SYNC_STAGES-1:0] aenSync_q;
	logic [15:0]            addrMeta_q;
	logic [15:0]            addrSync_q;
	logic [7:0]             dataMeta_q;
	logic [7:0]             dataSync_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdNSync_q  <= '1;
			wrNSync_q  <= '1;
			aenSync_q  <= '1;
			addrMeta_q <= 16'h0000;
			addrSync_q <= 16'h0000;
			dataMeta_q <= 8'h00;
			dataSync_q <= 8'h00;
		end else begin
			rdNSync_q  <= {rdNSync_q[0], isaRdN};
			wrNSync_q  <= {wrNSync_q[0], isaWrN};
			aenSync_q  <= {aenSync_q[0], isaAen};
			addrMeta_q <= isaAddr;
			addrSync_q <= addrMeta_q;
			dataMeta_q <= isaDataIn;
			dataSync_q <= dataMeta_q;
		end
	end

	logic rdLow;
	logic wrLow;
	logic hitData;
	logic hitCtrl;
	assign rdLow   = ~rdNSync_q[1];
	assign wrLow   = ~wrNSync_q[1];
	// aen high marks a dma cycle, never ours
	assign hitData = ~aenSync_q[1] & (addrSync_q == DATA_PORT_ADDR);
	assign hitCtrl = ~aenSync_q[1] & (addrSync_q == CTRL_PORT_ADDR);

	////////////////////////////////////////////////////////////////////////
	// strobe tracking: commit at the end of the strobe, when data is settled

	logic       wrActive_q;
	logic       wrHit_q;
	logic       wrCmd_q;
	logic [7:0] wrByte_q;
	logic       rdActive_q;
	logic       rdHitData_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrActive_q <= 1'b0;
			wrHit_q    <= 1'b0;
			wrCmd_q    <= 1'b0;
			wrByte_q   <= BYTE_RESET;
		end else begin
			wrActive_q <= wrLow;
			if (wrLow) begin
				wrHit_q  <= hitData | hitCtrl;
				wrCmd_q  <= addrSync_q[ADDR_CMD_BIT];
				wrByte_q <= dataSync_q;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdActive_q  <= 1'b0;
			rdHitData_q <= 1'b0;
		end else begin
			rdActive_q <= rdLow;
			if (rdLow) begin
				rdHitData_q <= hitData;
			end
		end
	end

	logic hostWrDone;
	logic hostRdDataDone;
	assign hostWrDone     = wrActive_q & ~wrLow & wrHit_q;
	assign hostRdDataDone = rdActive_q & ~rdLow & rdHitData_q;

	////////////////////////////////////////////////////////////////////////
	// mailbox bytes and flags

	logic [7:0]  inByte_q;
	logic [7:0]  outByte_q;
	host_flags_t flags_q;
	logic        flagsEn_q;
	logic [7:0]  port2_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			inByte_q <= BYTE_RESET;
		end else if (hostWrDone) begin
			inByte_q <= wrByte_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			outByte_q <= BYTE_RESET;
		end else if (ctrlReq.wrOutByte) begin
			outByte_q <= ctrlOutByte;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flagsEn_q <= 1'b0;
		end else if (ctrlReq.enFlags) begin
			flagsEn_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port2_q <= PORT2_RESET;
		end else if (ctrlReq.wrPort2) begin
			port2_q <= ctrlPortByte;
		end
	end

	// set beats clear on every flag; a status read has no effect
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags_q <= host_flags_t'(FLAGS_RESET);
		end else begin
			if (ctrlReq.wrFlags) begin
				flags_q.user7to4 <= ctrlFlagsByte[7:4];
				flags_q.user2    <= ctrlFlagsByte[2];
			end
			if (hostWrDone) begin
				flags_q.cmdFlag    <= wrCmd_q;
				flags_q.inFullFlag <= 1'b1;
			end else if (ctrlReq.rdInByte) begin
				flags_q.inFullFlag <= 1'b0;
			end
			if (ctrlReq.wrOutByte) begin
				flags_q.outFullFlag <= 1'b1;
			end else if (hostRdDataDone && flagsEn_q) begin
				flags_q.outFullFlag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host read drive

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			isaDataOe  <= 1'b0;
			isaDataOut <= BYTE_RESET;
		end else begin
			isaDataOe <= rdLow & (hitData | hitCtrl);
			if (hitData) begin
				isaDataOut <= outByte_q;
			end else begin
				isaDataOut <= flags_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host interrupt outputs

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			kbdIrqOut <= 1'b0;
			auxIrqOut <= 1'b0;
		end else if (flagsEn_q) begin
			kbdIrqOut <= port2_q[KBD_IRQ_PORT_BIT]
				& flags_q.outFullFlag;
			auxIrqOut <= port2_q[AUX_IRQ_PORT_BIT]
				& ~flags_q.inFullFlag;
		end else begin
			kbdIrqOut <= port2_q[KBD_IRQ_PORT_BIT];
			auxIrqOut <= port2_q[AUX_IRQ_PORT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// controller side views and internal interrupts

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrlInByte <= BYTE_RESET;
			ctrlFlags  <= host_flags_t'(FLAGS_RESET);
			ctrlPort   <= PORT2_RESET;
			irqInFull  <= 1'b0;
			irqTimer   <= 1'b0;
		end else begin
			ctrlInByte <= inByte_q;
			ctrlFlags  <= flags_q;
			ctrlPort   <= port2_q;
			irqInFull  <= flags_q.inFullFlag & ibfIrqEn;
			irqTimer   <= timerOverflow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gpio routing and watchdog kick

	logic kbdRstBitPrev_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gpioA20Pin      <= 1'b0;
			gpioKbdResetPin <= 1'b0;
			wdtKick         <= 1'b0;
			kbdRstBitPrev_q <= 1'b0;
		end else begin
			gpioA20Pin <= a20Route ? port2_q[A20_PORT_BIT]
				: a20UserOut;
			gpioKbdResetPin <= kbdRstRoute ? port2_q[KBD_RESET_PORT_BIT]
				: kbdRstUserOut;
			kbdRstBitPrev_q <= port2_q[KBD_RESET_PORT_BIT];
			// kick on a falling port bit only, so a held level kicks once
			wdtKick <= wdtKickEn & kbdRstBitPrev_q
				& ~port2_q[KBD_RESET_PORT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain serial pins

	localparam int SER_MAP [SER_PINS] = '{KBD_CLK_PORT_BIT,
		KBD_DAT_PORT_BIT, AUX_CLK_PORT_BIT, AUX_DAT_PORT_BIT};

	logic [SER_PINS-1:0] pinMeta_q;

	genvar gi;
	generate
		for (gi = 0; gi < SER_PINS; gi++) begin : g_ser
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					serPinOe[gi]  <= 1'b0;
					serPinOut[gi] <= 1'b0;
					pinMeta_q[gi] <= 1'b1;
					serSample[gi] <= 1'b1;
				end else begin
					// a one on the port bit pulls the pin low
					serPinOe[gi]  <= port2_q[SER_MAP[gi]];
					serPinOut[gi] <= 1'b0;
					pinMeta_q[gi] <= serPinIn[gi];
					serSample[gi] <= pinMeta_q[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// power-down control

	core_state_t coreState_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			coreState_q <= CORE_RUN;
			wakeVector  <= 1'b0;
			wakeNext    <= 1'b0;
		end else begin
			wakeVector <= 1'b0;
			wakeNext   <= 1'b0;
			unique case (coreState_q)
				CORE_RUN: begin
					if (ctrlReq.stopInstr) begin
						coreState_q <= CORE_STOPPED;
					end else if (ctrlReq.haltInstr) begin
						coreState_q <= CORE_HALTED;
					end
				end
				CORE_HALTED, CORE_STOPPED: begin
					if (hostWrDone) begin
						coreState_q <= CORE_RUN;
						wakeVector  <= ibfIrqEn;
						wakeNext    <= ~ibfIrqEn;
					end
				end
			endcase
		end
	end

	// reset always restarts from address zero, whatever the state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			coreRestart <= 1'b1;
			aluClkEn    <= 1'b0;
			oscEn       <= 1'b1;
		end else begin
			coreRestart <= 1'b0;
			aluClkEn    <= (coreState_q == CORE_RUN);
			oscEn       <= (coreState_q != CORE_STOPPED);
		end
	end

endmodule

// *** keyboard_host_port_chk.sv ***
// assertions on the keyboard host port pins
`timescale 1ns/1ps
module keyboard_host_port_chk
	import keyboard_host_port_pkg::*;
(
	input wire logic                core_clk,
	input wire logic                rst,
	input wire logic [15:0]         isaAddr,
	input wire logic                isaAen,
	input wire logic                isaRdN,
	input wire logic                isaDataOe,
	input wire logic                kbdIrqOut,
	input wire logic                auxIrqOut,
	input wire ctrl_req_t           ctrlReq,
	input wire host_flags_t         ctrlFlags,
	input wire logic [7:0]          ctrlPort,
	input wire logic                aluClkEn,
	input wire logic                oscEn,
	input wire logic [SER_PINS-1:0] serPinOut,
	input wire logic [SER_PINS-1:0] serPinOe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// checked while reset is high, so no disable here
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		rst |-> !kbdIrqOut && ctrlFlags == FLAGS_RESET)
		else $error("irq or flags not cleared in reset");
	AST_PULL_LOW_ONLY: assert property (serPinOut == '0)
		else $error("serial pin driven high");
	AST_PIN_MAP: assert property (
		serPinOe == {ctrlPort[2], ctrlPort[3], ctrlPort[7], ctrlPort[6]})
		else $error("serial pin enables do not match port bits");
	AST_KBD_IRQ_LOW: assert property (!ctrlPort[4] |-> !kbdIrqOut)
		else $error("kbd irq high with its port bit low");
	AST_AUX_IRQ_LOW: assert property (!ctrlPort[5] |-> !auxIrqOut)
		else $error("aux irq high with its port bit low");
	AST_OUT_FULL_SET: assert property (
		ctrlReq.wrOutByte |-> ##2 ctrlFlags.outFullFlag)
		else $error("out full not set by controller write");
	AST_IN_FULL_CLR: assert property (
		ctrlReq.rdInByte |-> ##2 !ctrlFlags.inFullFlag)
		else $error("in full not cleared by controller read");
	AST_READ_DRIVE: assert property ($fell(isaRdN) && !isaAen &&
		(isaAddr == DATA_PORT_ADDR || isaAddr == CTRL_PORT_ADDR)
		|-> ##[2:4] isaDataOe)
		else $error("host read not answered");
	AST_HALT_ALU: assert property (
		ctrlReq.haltInstr && !ctrlReq.stopInstr |-> ##2 !aluClkEn)
		else $error("alu clock runs after halt");
	AST_STOP_OSC: assert property (ctrlReq.stopInstr |-> ##2 !oscEn)
		else $error("oscillator runs after stop");
endmodule

// *** isa_host.sv ***
// isa host model issuing port reads and writes
`timescale 1ns/1ps
module isa_host (
	input  wire logic        core_clk,
	input  wire logic [7:0]  isaDataOut,
	input  wire logic        isaDataOe,
	output logic      [15:0] isaAddr,
	output logic             isaAen,
	output logic             isaRdN,
	output logic             isaWrN,
	output logic      [7:0]  isaDataIn
);
	initial begin
		isaAddr = 16'hffff;
		isaAen = 1'b0;
		isaRdN = 1'b1;
		isaWrN = 1'b1;
		isaDataIn = 8'h00;
	end
	// strobes held four cycles, idle six: the sync needs three each way
	task automatic wr(input logic [15:0] a, input logic [7:0] dt);
		@(negedge core_clk);
		isaAddr = a;
		isaDataIn = dt;
		isaWrN = 1'b0;
		repeat (4) @(negedge core_clk);
		isaWrN = 1'b1;
		repeat (6) @(negedge core_clk);
		isaDataIn = ~dt;
		isaAddr = ~a;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] dt);
		int n;
		@(negedge core_clk);
		isaAddr = a;
		isaRdN = 1'b0;
		// look at the enable and data off the edge that launches them
		for (n = 0; n < 8 && isaDataOe !== 1'b1; n++)
			@(negedge core_clk);
		dt = isaDataOut;
		@(negedge core_clk);
		isaRdN = 1'b1;
		repeat (6) @(negedge core_clk);
		isaAddr = ~a;
	endtask
endmodule

// *** keyboard_host_port_tb.sv ***
// self-checking bench for the keyboard host port
`timescale 1ns/1ps
module keyboard_host_port_tb import keyboard_host_port_pkg::*;;
	typedef struct packed {
		logic [7:0] pb;
		logic       rt;
		logic       uo;
		logic [3:0] oe;
		logic [3:0] out;
	} row_t;
	// port byte, route, user level, pin enables, {kbd, aux, a20, reset}
	row_t rows [7] = '{{8'h00, 2'b10, 4'h0, 4'h0}, {8'h30, 2'b10, 4'h0, 4'hc},
		{8'hc0, 2'b10, 4'h3, 4'h0}, {8'h0c, 2'b10, 4'hc, 4'h0},
		{8'h03, 2'b10, 4'h0, 4'h3}, {8'h03, 2'b00, 4'h0, 4'h0},
		{8'h00, 2'b01, 4'h0, 4'h3}};
	logic        core_clk = 1'b0;
	logic        rst, isaAen, isaRdN, isaWrN, isaDataOe, kbdIrqOut, auxIrqOut;
	logic [15:0] isaAddr;
	logic [7:0]  isaDataIn, isaDataOut, ctrlOutByte, ctrlFlagsByte, d;
	logic [7:0]  ctrlPortByte, ctrlInByte;
	logic        ibfIrqEn, timerOverflow, irqInFull, irqTimer, aluClkEn;
	logic        oscEn, wakeVector, coreRestart, a20Route, kbdRstRoute;
	logic        a20UserOut, kbdRstUserOut, gpioA20Pin, gpioKbdResetPin;
	logic        sawVec = 1'b0;
	logic        sawNext = 1'b0;
	logic        wdtKickEn, wdtKick, wakeNext;
	logic [7:0]  kicks = 8'h00;
	logic [3:0]  serPinIn, serPinOe, serSample;
	ctrl_req_t   ctrlReq;
	host_flags_t ctrlFlags;
	row_t        r;
	int          miscompares = 0;
	int          comparisons = 0;
	int          i;
	////////////////////////////////////////////////////////////////////////
	always #10 core_clk = ~core_clk;
	assign serPinIn = ~serPinOe;
	always @(posedge core_clk) if (wakeVector === 1'b1) sawVec <= 1'b1;
	always @(posedge core_clk) if (wakeNext === 1'b1) sawNext <= 1'b1;
	always @(posedge core_clk) if (wdtKick === 1'b1) kicks <= kicks + 8'h01;
	keyboard_host_port u_keyboard_host_port (.core_clk(core_clk), .rst(rst),
		.isaAddr(isaAddr), .isaAen(isaAen), .isaRdN(isaRdN),
		.isaWrN(isaWrN), .isaDataIn(isaDataIn), .isaDataOut(isaDataOut),
		.isaDataOe(isaDataOe), .kbdIrqOut(kbdIrqOut), .auxIrqOut(auxIrqOut),
		.ctrlReq(ctrlReq), .ctrlOutByte(ctrlOutByte),
		.ctrlFlagsByte(ctrlFlagsByte), .ctrlPortByte(ctrlPortByte),
		.ibfIrqEn(ibfIrqEn), .timerOverflow(timerOverflow),
		.ctrlInByte(ctrlInByte), .ctrlFlags(ctrlFlags), .ctrlPort(),
		.irqInFull(irqInFull), .irqTimer(irqTimer), .aluClkEn(aluClkEn),
		.oscEn(oscEn), .wakeVector(wakeVector), .wakeNext(wakeNext),
		.coreRestart(coreRestart), .a20Route(a20Route),
		.kbdRstRoute(kbdRstRoute), .a20UserOut(a20UserOut),
		.kbdRstUserOut(kbdRstUserOut), .wdtKickEn(wdtKickEn),
		.gpioA20Pin(gpioA20Pin), .gpioKbdResetPin(gpioKbdResetPin),
		.wdtKick(wdtKick), .serPinIn(serPinIn), .serPinOut(),
		.serPinOe(serPinOe),
		.serSample(serSample));
	isa_host u_isa_host (.core_clk(core_clk), .isaDataOut(isaDataOut),
		.isaDataOe(isaDataOe), .isaAddr(isaAddr), .isaAen(isaAen),
		.isaRdN(isaRdN), .isaWrN(isaWrN), .isaDataIn(isaDataIn));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse(input logic [6:0] q);
		@(negedge core_clk);
		ctrlReq = ctrl_req_t'(q);
		@(negedge core_clk);
		ctrlReq = '0;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// whole run is a few hundred cycles
	initial begin
		#400000;
		miscompares++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, ctrlOutByte, ctrlFlagsByte, ctrlPortByte} = '1;
		ctrlReq = '0;
		{ibfIrqEn, timerOverflow, a20Route, kbdRstRoute} = '0;
		{a20UserOut, kbdRstUserOut} = '0;
		wdtKickEn = 1'b1;
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		for (i = 0; i < 7; i++) begin
			r = rows[i];
			ctrlPortByte = r.pb;
			{a20Route, kbdRstRoute} = {2{r.rt}};
			{a20UserOut, kbdRstUserOut} = {2{r.uo}};
			pulse(7'h08);
			repeat (2) @(negedge core_clk);
			chk("serPinOe", {4'h0, r.oe}, {4'h0, serPinOe});
			chk("serSample", {4'h0, ~r.oe}, {4'h0, serSample});
			chk("irq gpio", {4'h0, r.out}, {4'h0, kbdIrqOut, auxIrqOut,
				gpioA20Pin, gpioKbdResetPin});
		end
		// only the last row drops port bit 0
		chk("wdtKick", 8'h01, kicks);
		timerOverflow = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("irqTimer", 8'h01, {7'h0, irqTimer});
		timerOverflow = 1'b0;
		u_isa_host.wr(16'h0060, 8'h5a);
		chk("inByte", 8'h5a, ctrlInByte);
		chk("flags", 8'h02, ctrlFlags);
		u_isa_host.wr(16'h0064, 8'ha5);
		u_isa_host.wr(16'h0064, 8'h3c);
		chk("inByte", 8'h3c, ctrlInByte);
		chk("flags", 8'h0a, ctrlFlags);
		u_isa_host.rd(16'h0064, d);
		chk("status", 8'h0a, d);
		chk("flags", 8'h0a, ctrlFlags);
		u_isa_host.isaAen = 1'b1;
		u_isa_host.wr(16'h0060, 8'h11);
		u_isa_host.isaAen = 1'b0;
		u_isa_host.wr(16'h0061, 8'h22);
		chk("inByte", 8'h3c, ctrlInByte);
		pulse(7'h20);
		chk("flags", 8'h08, ctrlFlags);
		pulse(7'h04);
		ctrlPortByte = 8'h30;
		pulse(7'h08);
		ctrlOutByte = 8'h77;
		pulse(7'h40);
		chk("flags", 8'h09, ctrlFlags);
		chk("irqs", 8'h03, {6'h0, kbdIrqOut, auxIrqOut});
		u_isa_host.wr(16'h0060, 8'h44);
		chk("irqs", 8'h02, {6'h0, kbdIrqOut, auxIrqOut});
		u_isa_host.rd(16'h0060, d);
		chk("dataOut", 8'h77, d);
		chk("irqs", 8'h00, {6'h0, kbdIrqOut, auxIrqOut});
		chk("flags", 8'h02, ctrlFlags);
		pulse(7'h40);
		ctrlPortByte = 8'h20;
		pulse(7'h08);
		chk("irqs", 8'h00, {6'h0, kbdIrqOut, auxIrqOut});
		ctrlFlagsByte = 8'hff;
		pulse(7'h10);
		u_isa_host.rd(16'h0064, d);
		chk("status", 8'hf7, d);
		wdtKickEn = 1'b0;
		ctrlPortByte = 8'h01;
		pulse(7'h08);
		ctrlPortByte = 8'h00;
		pulse(7'h08);
		chk("wdtKick", 8'h01, kicks);
		ibfIrqEn = 1'b1;
		pulse(7'h20);
		pulse(7'h02);
		chk("aluClkEn", 8'h00, {7'h0, aluClkEn});
		u_isa_host.wr(16'h0060, 8'h01);
		chk("aluClkEn", 8'h01, {7'h0, aluClkEn});
		chk("wakeVector", 8'h01, {7'h0, sawVec});
		chk("irqInFull", 8'h01, {7'h0, irqInFull});
		ibfIrqEn = 1'b0;
		pulse(7'h02);
		u_isa_host.wr(16'h0060, 8'h02);
		chk("wakeNext", 8'h01, {7'h0, sawNext});
		chk("irqInFull", 8'h00, {7'h0, irqInFull});
		pulse(7'h01);
		chk("oscEn", 8'h00, {7'h0, oscEn});
		rst = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("coreRestart", 8'h01, {7'h0, coreRestart});
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("power", 8'h03, {6'h0, oscEn, aluClkEn});
		chk("flags", 8'h00, ctrlFlags);
		chk("kbdIrq", 8'h00, {7'h0, kbdIrqOut});
		print_verdict();
	end
endmodule
bind keyboard_host_port keyboard_host_port_chk u_keyboard_host_port_chk (
	.core_clk(core_clk), .rst(rst), .isaAddr(isaAddr), .isaAen(isaAen),
	.isaRdN(isaRdN), .isaDataOe(isaDataOe), .kbdIrqOut(kbdIrqOut),
	.auxIrqOut(auxIrqOut), .ctrlReq(ctrlReq), .ctrlFlags(ctrlFlags),
	.ctrlPort(ctrlPort), .aluClkEn(aluClkEn), .oscEn(oscEn),
	.serPinOut(serPinOut), .serPinOe(serPinOe));
